// file: src/hims_map.svh
// Constants of the host interface mode selector.
// Assumes inclusion by the package and the design file.
`ifndef HIMS_MAP_SVH
`define HIMS_MAP_SVH

// Word that enters the queue
`define HIMS_WORD_W   24
`define HIMS_FIFO_D   16
`define HIMS_PAR_W    12
// Serial frame last bit index; the frame is 24 bits
`define HIMS_SPI_LAST 5'h17
// I2C slave address, value arbitrary
`define HIMS_I2C_ADR  7'h2a
`define HIMS_I2C_LAST 2'h2
// Queue strap is sampled again after reset release
`define HIMS_QPEND_RST 1'b1
`define HIMS_QLAT_RST  1'b0

`endif

// file: src/hims_pkg.sv
// Types of the host interface mode selector.
// Assumes the map header is on the include path.
package hims_pkg;
	`include "hims_map.svh"
	typedef enum logic [1:0] {
		HIMS_PAR, HIMS_SPI, HIMS_I2C
	} hims_mode_t;
	typedef enum logic [2:0] {
		HI_IDLE, HI_ADDR, HI_ACKA, HI_DATA, HI_ACKD
	} hims_i2c_t;
endpackage

// file: src/hims_top.sv
// Host interface mode selector with write queue.
// Assumes pins arrive unsynchronised; link clock is the serial clock pin.
`timescale 1ns/1ps
`include "hims_map.svh"

module hims_fifo #(
	parameter int W = 24,
	parameter int D = 16
) (
	input  wire logic         i_clk_sys, // System clock
	input  wire logic         i_rst_b,   // Sync reset
	input  wire logic         i_valid,   // Write valid
	output logic              o_ready,   // Not full
	input  wire logic [W-1:0] i_data,    // Write word
	output logic              o_valid,   // Not empty
	input  wire logic         i_ready,   // Drain ready
	output logic [W-1:0]      o_data     // Head word
);
	localparam int A = $clog2(D);
	logic [W-1:0] mem_ff [D];
	logic [A-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic [A:0]   cnt_ff, nxt_cnt;
	logic         wr, rd;

	assign o_ready = (cnt_ff != D[A:0]);
	assign o_valid = (cnt_ff != '0);
	assign o_data  = mem_ff[rp_ff];

	always_comb begin
		wr      = i_valid && o_ready;
		rd      = o_valid && i_ready;
		nxt_wp  = wr ? wp_ff + 1'b1 : wp_ff;
		nxt_rp  = rd ? rp_ff + 1'b1 : rp_ff;
		nxt_cnt = cnt_ff + {{A{1'b0}}, wr} - {{A{1'b0}}, rd};
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff  <= nxt_wp;
			rp_ff  <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
		if (wr) begin
			mem_ff[wp_ff] <= i_data;
		end
	end
endmodule

module hims_top
	import hims_pkg::*;
(
	input  wire logic        i_clk_sys,             // System clock
	input  wire logic        i_rst_b,               // Sync reset
	input  wire logic        i_shared_bit12_pin,    // SCLK or SCL
	input  wire logic        i_sync_b,              // SPI frame select
	input  wire logic        i_serial_parallel_strap, // 1 serial
	input  wire logic        i_queue_enable_strap,  // Queue strap
	input  wire logic        i_interface_select_pin, // Bit 9 or select
	input  wire logic        i_shared_bit10_clock_pin, // Bit 10
	input  wire logic        i_shared_bit11_data_pin, // Bit 11, DIN, SDA
	input  wire logic [8:0]  i_par_low,             // Bits 8..0
	input  wire logic        i_par_wr_b,            // Parallel write
	input  wire logic        i_clear_b,             // Clear event
	output logic             o_sda_out,             // SDA level, low
	output logic             o_sda_oe,              // SDA pulled low
	output logic             o_sdo,                 // SPI readback
	output logic             o_sdo_oe,              // SDO drive
	output logic [1:0]       o_mode,                // Decoded mode
	output logic             o_queue_active,        // Queue on
	output logic             o_par_ready,           // Parallel may write
	output logic             o_word_valid,          // Word available
	input  wire logic        i_word_ready,          // Word taken
	output logic [23:0]      o_word_data            // Received word
);
	localparam int NS = 17;

	////////////////////////////////////////////////////////////////
	// Pin synchroniser, three stages, change on agreement
	logic [NS-1:0] pin, s1_ff, s2_ff, s3_ff, st_ff, nxt_st, prv_ff;
	always_comb begin
		pin = {i_serial_parallel_strap, i_queue_enable_strap,
			i_interface_select_pin, i_shared_bit10_clock_pin,
			i_shared_bit11_data_pin, i_shared_bit12_pin,
			i_par_wr_b, i_clear_b, i_par_low};
		nxt_st = st_ff;
		for (int i = 0; i < NS; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_st[i] = s3_ff[i];
			end
		end
	end
	always_ff @(posedge i_clk_sys) begin
		s1_ff <= pin;
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
		if (!i_rst_b) begin
			st_ff  <= {2'h0, 3'h0, 3'h7, 9'h1ff};
			prv_ff <= {2'h0, 3'h0, 3'h7, 9'h1ff};
		end else begin
			st_ff  <= nxt_st;
			prv_ff <= st_ff;
		end
	end
	logic sp, qs, sel, b10, b11, scl, wr_b, clr_b;
	assign {sp, qs, sel, b10, b11, scl, wr_b, clr_b} = st_ff[16:9];
	logic wr_fall, clr_fall, scl_rise, scl_fall, sda_fall, sda_rise;
	assign wr_fall  = prv_ff[10] && !wr_b;
	assign clr_fall = prv_ff[9] && !clr_b;
	assign scl_rise = !prv_ff[11] && scl;
	assign scl_fall = prv_ff[11] && !scl;
	assign sda_fall = prv_ff[12] && !b11 && scl;
	assign sda_rise = !prv_ff[12] && b11 && scl;

	////////////////////////////////////////////////////////////////
	// Mode decode and queue strap latch
	hims_mode_t mode;
	logic qpend_ff, nxt_qpend, qlat_ff, nxt_qlat;
	always_comb begin
		if (!sp) begin
			mode = HIMS_PAR;
		end else if (sel) begin
			mode = HIMS_I2C;
		end else begin
			mode = HIMS_SPI;
		end
		nxt_qpend = clr_fall;
		// Agreed pin level, so the latch after reset sees the strap
		nxt_qlat  = qpend_ff ? nxt_st[15] : qlat_ff;
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			qpend_ff <= `HIMS_QPEND_RST;
			qlat_ff  <= `HIMS_QLAT_RST;
		end else begin
			qpend_ff <= nxt_qpend;
			qlat_ff  <= nxt_qlat;
		end
	end
	assign o_queue_active = qlat_ff && (mode == HIMS_PAR);
	assign o_mode = mode;

	////////////////////////////////////////////////////////////////
	// SPI link domain: pin 12 clock, pin 11 data
	logic [23:0] sr_ff, nxt_sr, hold_ff, nxt_hold;
	logic [4:0]  bc_ff, nxt_bc;
	logic        tg_ff, nxt_tg, sdo_ff;
	always_comb begin
		nxt_sr   = {sr_ff[22:0], i_shared_bit11_data_pin};
		nxt_bc   = bc_ff + 5'h01;
		nxt_hold = hold_ff;
		nxt_tg   = tg_ff;
		if (bc_ff == `HIMS_SPI_LAST) begin
			nxt_bc   = 5'h00;
			nxt_hold = nxt_sr;
			nxt_tg   = !tg_ff;
		end
	end
	// Frame select ends a frame without a link edge
	always_ff @(negedge i_shared_bit12_pin or posedge i_sync_b) begin
		if (i_sync_b) begin
			bc_ff <= 5'h00;
		end else begin
			bc_ff <= nxt_bc;
		end
	end
	always_ff @(negedge i_shared_bit12_pin) begin
		if (!i_sync_b) begin
			sr_ff   <= nxt_sr;
			hold_ff <= nxt_hold;
		end
	end
	// Toggle starts known; reset is released while the link is idle
	always_ff @(negedge i_shared_bit12_pin or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tg_ff <= 1'b0;
		end else if (!i_sync_b) begin
			tg_ff <= nxt_tg;
		end
	end
	always_ff @(posedge i_shared_bit12_pin) begin
		sdo_ff <= sr_ff[23];
	end
	assign o_sdo    = sdo_ff;
	assign o_sdo_oe = !i_sync_b && (mode == HIMS_SPI);

	////////////////////////////////////////////////////////////////
	// SPI word crossing: toggle through three stages
	logic t1_ff, t2_ff, t3_ff, tst_ff, nxt_tst;
	assign nxt_tst = (t2_ff == t3_ff) ? t3_ff : tst_ff;
	always_ff @(posedge i_clk_sys) begin
		t1_ff <= tg_ff;
		t2_ff <= t1_ff;
		t3_ff <= t2_ff;
		if (!i_rst_b) begin
			tst_ff <= 1'b0;
		end else begin
			tst_ff <= nxt_tst;
		end
	end
	logic spi_evt;
	assign spi_evt = (nxt_tst != tst_ff) && (mode == HIMS_SPI);

	////////////////////////////////////////////////////////////////
	// I2C slave on synchronised pins, each level held at least two system clocks
	hims_i2c_t is_ff, nxt_is;
	logic [3:0]  ib_ff, nxt_ib;
	logic [1:0]  iy_ff, nxt_iy;
	logic [23:0] iw_ff, nxt_iw;
	logic        oe_ff, nxt_oe, ievt_ff, nxt_ievt, fready;
	always_comb begin
		nxt_is   = is_ff;
		nxt_ib   = ib_ff;
		nxt_iy   = iy_ff;
		nxt_iw   = iw_ff;
		nxt_oe   = oe_ff;
		nxt_ievt = 1'b0;
		// Acknowledge slots are not shifted in
		if (scl_rise && (is_ff == HI_ADDR || is_ff == HI_DATA)) begin
			nxt_iw = {iw_ff[22:0], b11};
			nxt_ib = ib_ff + 4'h1;
		end
		unique case (is_ff)
			HI_IDLE: nxt_oe = 1'b0;
			HI_ADDR: begin
				if (scl_fall && ib_ff == 4'h8) begin
					if (iw_ff[7:0] == {`HIMS_I2C_ADR, 1'b0}) begin
						nxt_is = HI_ACKA;
						nxt_oe = 1'b1;
					end else begin
						nxt_is = HI_IDLE;
					end
				end
			end
			HI_ACKA, HI_ACKD: begin
				if (scl_fall) begin
					nxt_is = HI_DATA;
					nxt_oe = 1'b0;
					nxt_ib = 4'h0;
				end
			end
			HI_DATA: begin
				if (scl_fall && ib_ff == 4'h8) begin
					nxt_iy = iy_ff + 2'h1;
					if (iy_ff != `HIMS_I2C_LAST) begin
						nxt_is = HI_ACKD;
						nxt_oe = 1'b1;
					end else if (fready) begin
						nxt_is   = HI_ACKD;
						nxt_oe   = 1'b1;
						nxt_iy   = 2'h0;
						nxt_ievt = 1'b1;
					end else begin
						nxt_is = HI_IDLE;
					end
				end
			end
		endcase
		if (sda_fall) begin
			nxt_is = HI_ADDR;
			nxt_ib = 4'h0;
			nxt_iy = 2'h0;
			nxt_oe = 1'b0;
		end
		if (sda_rise || mode != HIMS_I2C) begin
			nxt_is = HI_IDLE;
			nxt_oe = 1'b0;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			is_ff   <= HI_IDLE;
			ib_ff   <= 4'h0;
			iy_ff   <= 2'h0;
			iw_ff   <= 24'h000000;
			oe_ff   <= 1'b0;
			ievt_ff <= 1'b0;
		end else begin
			is_ff   <= nxt_is;
			ib_ff   <= nxt_ib;
			iy_ff   <= nxt_iy;
			iw_ff   <= nxt_iw;
			oe_ff   <= nxt_oe;
			ievt_ff <= nxt_ievt;
		end
	end
	assign o_sda_out = 1'b0;
	assign o_sda_oe  = oe_ff;

	////////////////////////////////////////////////////////////////
	// Word staging into the queue
	logic        pv_ff, nxt_pv, fv, fempty_n;
	logic [23:0] pd_ff, nxt_pd;
	logic        par_ok;
	// without queue, one word at a time
	assign par_ok = o_queue_active ? fready : !fempty_n && !pv_ff;
	assign o_par_ready = (mode == HIMS_PAR) && par_ok;
	always_comb begin
		nxt_pv = pv_ff && !fready;
		nxt_pd = pd_ff;
		if (!nxt_pv) begin
			if (mode == HIMS_PAR && wr_fall && par_ok) begin
				nxt_pv = 1'b1;
				nxt_pd = {12'h000, b11, b10, sel, st_ff[8:0]};
			end else if (spi_evt) begin
				nxt_pv = 1'b1;
				nxt_pd = hold_ff;
			end else if (ievt_ff) begin
				nxt_pv = 1'b1;
				nxt_pd = iw_ff;
			end
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			pv_ff <= 1'b0;
			pd_ff <= 24'h000000;
		end else begin
			pv_ff <= nxt_pv;
			pd_ff <= nxt_pd;
		end
	end
	hims_fifo #(.W(`HIMS_WORD_W), .D(`HIMS_FIFO_D)) u_fifo (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_valid   (pv_ff),
		.o_ready   (fready),
		.i_data    (pd_ff),
		.o_valid   (fv),
		.i_ready   (i_word_ready),
		.o_data    (o_word_data)
	);
	assign fempty_n     = fv;
	assign o_word_valid = fv;

	////////////////////////////////////////////////////////////////
	// Checks
	property p_qpar;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_queue_active |-> mode == HIMS_PAR && qlat_ff;
	endproperty
	a_qpar: assert property (p_qpar) else $error("queue on outside parallel");
	property p_qlat;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		clr_fall |=> ##1 qlat_ff == qs;
	endproperty
	a_qlat: assert property (p_qlat) else $error("strap not latched");
	property p_bit9;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		mode == HIMS_PAR && wr_fall && par_ok && !pv_ff
		|=> pd_ff[11:9] == $past({b11, b10, sel});
	endproperty
	a_bit9: assert property (p_bit9) else $error("parallel bits wrong");
	property p_spi;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		sp && !sel |-> mode == HIMS_SPI ##1 !o_sda_oe;
	endproperty
	a_spi: assert property (p_spi) else $error("spi mode not chosen");
	property p_i2c;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		sp && sel |-> mode == HIMS_I2C && !o_sdo_oe;
	endproperty
	a_i2c: assert property (p_i2c) else $error("i2c mode not chosen");
	property p_shift;
		@(negedge i_shared_bit12_pin) disable iff (i_sync_b)
		1 |=> sr_ff[0] == $past(i_shared_bit11_data_pin);
	endproperty
	a_shift: assert property (p_shift) else $error("spi bit lost");
	property p_sdo;
		@(posedge i_shared_bit12_pin) disable iff (i_sync_b)
		1 |=> o_sdo == $past(sr_ff[23]);
	endproperty
	a_sdo: assert property (p_sdo) else $error("readback late");
	property p_ack;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		$rose(is_ff == HI_ACKA) |-> o_sda_oe && o_sda_out == 1'b0;
	endproperty
	a_ack: assert property (p_ack) else $error("no address ack");
	property p_idle;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		mode != HIMS_I2C |=> is_ff == HI_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("i2c active off mode");
	c_par: cover property (@(posedge i_clk_sys) pv_ff && mode == HIMS_PAR);
	c_spi: cover property (@(posedge i_clk_sys) spi_evt);
	c_i2c: cover property (@(posedge i_clk_sys) ievt_ff);
	c_full: cover property (@(posedge i_clk_sys) !fready);
endmodule

// file: test/hims_host_model.sv
// Host side model: SPI frames and I2C transfers on the shared serial pins.
// Assumes the bench resolves SDA from the device's pull-down enable.
`timescale 1ns/1ps
module hims_host_model (
	input  wire logic i_sdo,    // SPI readback
	input  wire logic i_sda,    // Resolved SDA level
	output logic      o_b12,    // SCLK or SCL
	output logic      o_sync_b, // SPI frame select
	output logic      o_b11     // DIN or SDA release
);
	logic [23:0] rb;

	initial begin
		o_b12 = 1'b1;
		o_sync_b = 1'b1;
		o_b11 = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// data stable at fall
	task automatic spi(input logic [23:0] w);
		o_sync_b = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			o_b11 = w[i];
			#6 rb[i] = i_sdo;
			o_b12 = 1'b0;
			#6 o_b12 = 1'b1;
		end
		#6 o_sync_b = 1'b1;
		o_b11 = ~o_b11;
	endtask

	////////////////////////////////////////////////////////////////
	// Start, four bytes with acknowledge slots, stop
	task automatic i2c(input int h, input logic [7:0] b[4], output logic [3:0] ack);
		o_b11 = 1'b1;
		#h o_b11 = 1'b0;
		#h o_b12 = 1'b0;
		for (int k = 0; k < 4; k++) begin
			for (int i = 8; i >= 0; i--) begin
				#(h/2) o_b11 = (i == 0) ? 1'b1 : b[k][i-1];
				#(h/2) o_b12 = 1'b1;
				if (i == 0)
					ack[3-k] = ~i_sda;
				#h o_b12 = 1'b0;
			end
		end
		#(h/2) o_b11 = 1'b0;
		#(h/2) o_b12 = 1'b1;
		#h o_b11 = 1'b1;
		#h;
	endtask
endmodule

// file: test/hims_top_tb_top.sv
// Bench: mode decode, queue strap latch, queue fill, SPI and I2C traffic.
// Assumes the host model drives the serial pins; map header on include path.
`timescale 1ns/1ps
`include "hims_map.svh"
module hims_top_tb_top
	import hims_pkg::*;
;
	logic        clk = 1'b0, rst_b, sp = 1'b0, sl = 1'b0, qs = 1'b0;
	logic        b10 = 1'b0, pb11 = 1'b0, wr_b = 1'b1, clr_b = 1'b1;
	logic        rdy = 1'b0, hold = 1'b0;
	logic [8:0]  plow = 9'h000;
	wire         b12, sync_b, m_b11, b11;
	logic        sda_out, sda_oe, sdo, sdo_oe, qa, pr, wv;
	logic [1:0]  mode;
	logic [23:0] wd;
	logic [23:0] exp_q[$];
	int          mismatches = 0;
	int          comparisons = 0;

	always #4 clk = ~clk;
	assign b11 = sda_oe ? sda_out : (sp ? m_b11 : pb11);

	hims_top hims_top_inst (.i_clk_sys(clk), .i_rst_b(rst_b), .i_shared_bit12_pin(b12),
		.i_sync_b(sync_b), .i_serial_parallel_strap(sp), .i_queue_enable_strap(qs),
		.i_interface_select_pin(sl), .i_shared_bit10_clock_pin(b10),
		.i_shared_bit11_data_pin(b11), .i_par_low(plow), .i_par_wr_b(wr_b),
		.i_clear_b(clr_b), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_sdo(sdo),
		.o_sdo_oe(sdo_oe), .o_mode(mode), .o_queue_active(qa), .o_par_ready(pr),
		.o_word_valid(wv), .i_word_ready(rdy), .o_word_data(wd));

	hims_host_model hims_host_model_inst (.i_sdo(sdo), .i_sda(b11), .o_b12(b12),
		.o_sync_b(sync_b), .o_b11(m_b11));

	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic check(input logic [23:0] s, input logic [23:0] e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic results();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic setmode(input logic s, input logic l);
		@(posedge clk);
		sp <= s;
		sl <= l;
		qs <= s ? 1'b0 : qs;
		tick(8);
	endtask

	task automatic pulse_clear();
		clr_b <= 1'b0;
		tick(2);
		clr_b <= 1'b1;
		tick(8);
	endtask

	task automatic pwrite(input logic [11:0] w);
		logic ok;
		@(posedge clk);
		ok = pr;
		{pb11, b10, sl, plow} <= w;
		wr_b <= 1'b0;
		if (ok === 1'b1)
			exp_q.push_back({12'h000, w});
		tick(2);
		wr_b <= 1'b1;
		tick(10);
	endtask

	////////////////////////////////////////////////////////////////
	// Drain with random stalls, compare every popped word
	always @(posedge clk) begin
		if (rst_b && wv === 1'b1 && rdy === 1'b1)
			check(wd, exp_q.pop_front());
		rdy <= hold ? 1'b0 : 1'($urandom % 2);
	end

	initial begin
		tick(100000);
		mismatches++;
		results();
	end

	initial begin
		logic [23:0] w, prev;
		logic [7:0]  b[4];
		logic [3:0]  ack;
		void'($urandom(11489));
		rst_b <= 1'b0;
		tick(3);
		rst_b <= 1'b1;
		tick(8);
		for (int i = 0; i < 4; i++) begin
			setmode(i[1], i[0]);
			check(24'(mode), i[1] ? (i[0] ? 24'h2 : 24'h1) : 24'h0);
			check(24'(qa), 24'h0);
		end
		$display("mode decode test done");
		setmode(1'b0, 1'b0);
		qs <= 1'b1;
		tick(8);
		check(24'(qa), 24'h0);
		pulse_clear();
		check(24'(qa), 24'h1);
		$display("strap latch test done");
		hold <= 1'b1;
		for (int i = 0; i < 17; i++)
			pwrite(12'($urandom));
		check(24'(pr), 24'h0);
		check(24'(exp_q.size()), 24'h10);
		hold <= 1'b0;
		tick(80);
		check(24'(wv), 24'h0);
		qs <= 1'b0;
		pulse_clear();
		check(24'(qa), 24'h0);
		for (int i = 0; i < 4; i++) begin
			// Without queue a write is taken only once the queue is empty
			while (wv !== 1'b0)
				tick(1);
			pwrite(12'($urandom));
		end
		$display("parallel queue test done");
		setmode(1'b1, 1'b0);
		check(24'(sdo_oe), 24'h0);
		for (int i = 0; i < 3; i++) begin
			w = 24'($urandom);
			exp_q.push_back(w);
			hims_host_model_inst.spi(w);
			if (i > 0)
				check(hims_host_model_inst.rb, prev);
			prev = w;
			tick(20);
		end
		$display("spi test done");
		setmode(1'b1, 1'b1);
		for (int r = 0; r < 3; r++) begin
			b[0] = {(r == 2) ? (`HIMS_I2C_ADR ^ 7'h01) : `HIMS_I2C_ADR, 1'b0};
			for (int k = 1; k < 4; k++)
				b[k] = 8'($urandom);
			if (r < 2)
				exp_q.push_back({b[1], b[2], b[3]});
			hims_host_model_inst.i2c((r == 1) ? 5000 : 1250, b, ack);
			check(24'(ack), (r == 2) ? 24'h0 : 24'hf);
			tick(20);
		end
		check(24'(sda_out), 24'h0);
		check(24'(exp_q.size()), 24'h0);
		$display("i2c test done");
		results();
	end
endmodule
